//--- design/shift_unit_pkg.sv
// Purpose: Shared constants and operation codes for the shift unit
// Assumes: 32-bit data path, one operation per request
// Notes: Widths and field positions live here only
package shift_unit_pkg;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   localparam int POS_W = 5;
   localparam int OP_W = 4;
   // Count field tops: word form uses [5:0], halfword [4:0], short [3:0]
   localparam int WORD_CNT_MSB = 5;
   localparam int HALF_CNT_MSB = 4;
   localparam int SHORT_CNT_MSB = 3;
   localparam int IMM9_W = 9;
   localparam int IMM4_W = 4;
   localparam logic [DATA_W-1:0] MAX_POS = 32'h7FFFFFFF;
   localparam logic [DATA_W-1:0] MAX_NEG = 32'h80000000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
   localparam logic [DATA_W-1:0] ONES_WORD = 32'hFFFFFFFF;

   // Operation select from instruction decode
   typedef enum logic [OP_W-1:0] {
      OP_COMPARE_UNEQUAL_ACC = 4'h0,
      OP_BIT_AND_ACC = 4'h1,
      OP_BIT_AND_INV_ACC = 4'h2,
      OP_BIT_NAND_ACC = 4'h3,
      OP_BIT_NOR_ACC = 4'h4,
      OP_BIT_OR_ACC = 4'h5,
      OP_BIT_OR_INV_ACC = 4'h6,
      OP_BIT_XNOR_ACC = 4'h7,
      OP_BIT_XOR_ACC = 4'h8,
      OP_ARITH_SHIFT = 4'h9,
      OP_ARITH_SHIFT_SHORT = 4'hA,
      OP_HALF_ARITH_SHIFT = 4'hB,
      OP_SAT_ARITH_SHIFT = 4'hC
   } shift_op_t;
endpackage

//--- design/arith_shifter.sv
// Purpose: Signed-count arithmetic shifter for one lane of width W
// Assumes: Count is a two's complement value wide enough for -W..W-1
// Notes: Purely combinational; carry is the OR of bits shifted out
`timescale 1ns/1ns
module arith_shifter #(
   parameter int W = 32,
   parameter int CW = 6
)
(
   // Operand and signed count
   input wire logic [W-1:0] value,
   input wire logic signed [CW-1:0] count,
   // Shifted value and status
   output logic [W-1:0] result,
   output logic shifted_out_or,
   output logic sign_lost
);
   // Double-width working copies keep the shifted-out bits visible
   logic [2*W-1:0] left_wide;
   logic [2*W-1:0] right_wide;
   logic [2*W-1:0] sign_ext_val;
   // Zero-extended copy, so only real value bits count as spilled
   logic [2*W-1:0] zero_wide;
   logic [CW-1:0] mag;

   always_comb
   begin
      mag = count[CW-1] ? CW'(-count) : CW'(count);
      sign_ext_val = {{W{value[W-1]}}, value};
      left_wide = sign_ext_val << mag;
      zero_wide = {{W{1'b0}}, value} << mag;
      right_wide = {value, {W{1'b0}}};
      right_wide = (2*W)'($signed(right_wide) >>> mag);
      if (count[CW-1])
      begin
         // Right shift: sign fill, spilled bits land in low half
         result = right_wide[2*W-1:W];
         shifted_out_or = |right_wide[W-1:0];
         sign_lost = 1'b0;
      end
      else
      begin
         // Left shift: zero fill, spilled bits in upper half
         result = left_wide[W-1:0];
         shifted_out_or = |zero_wide[2*W-1:W];
         // Any spilled sign copy disagreeing with the new sign bit
         sign_lost = (left_wide[2*W-1:W-1] != {(W+1){left_wide[W-1]}});
      end
   end
endmodule // arith_shifter

//--- design/shift_compare_accumulate_unit.sv
// Purpose: Compare, bit-logic accumulate and arithmetic shift datapath
// Assumes: Decode presents operands and op with a one-cycle start pulse
// Notes: Result, destination index and carry appear one cycle later
`timescale 1ns/1ns
// What this block does
// RL1: Unequal compare shifts destination, sets bit zero
// RL2: Bit-logic ops shift destination, insert logic bit
// RL3: Word shift count is signed six bits
// RL4: Positive left zero fill, negative right sign fill
// RL5: Carry is OR of shifted bits, zero clears
// RL6: Short form uses signed four-bit count, same register
// RL7: Halfword shifts stay within halves, five-bit count
// RL8: Halfword right shifts fill with own sign
// RL9: Saturating shift saturates when sign bits lost
// RL10: Saturating shift count signed six bits, sign fill
// RL11: Saturate to max positive or most negative
// RL12: One result per instruction, to named destination
module shift_compare_accumulate_unit #(
   parameter int REG_IDX_W = 4
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Request from decode
   input wire logic start,
   input wire logic [shift_unit_pkg::OP_W-1:0] op,
   input wire logic use_imm,
   input wire logic [shift_unit_pkg::IMM9_W-1:0] nine_bit_immediate,
   input wire logic [shift_unit_pkg::IMM4_W-1:0] four_bit_immediate,
   input wire logic [shift_unit_pkg::POS_W-1:0] first_bit_position,
   input wire logic [shift_unit_pkg::POS_W-1:0] second_bit_position,
   input wire logic [REG_IDX_W-1:0] dest_idx,
   input wire logic [REG_IDX_W-1:0] src_idx,
   // Operands from the data register file
   input wire logic [shift_unit_pkg::DATA_W-1:0] operand_a,
   input wire logic [shift_unit_pkg::DATA_W-1:0] operand_b,
   input wire logic [shift_unit_pkg::DATA_W-1:0] destination_operand,
   // Write-back to the data register file
   output logic result_valid,
   output logic [REG_IDX_W-1:0] result_idx,
   output logic [shift_unit_pkg::DATA_W-1:0] result,
   output logic carry_write,
   output logic carry_status_flag
);
   localparam int DW = shift_unit_pkg::DATA_W;
   localparam int HW = shift_unit_pkg::HALF_W;
   localparam int WC = shift_unit_pkg::WORD_CNT_MSB + 1;
   localparam int HC = shift_unit_pkg::HALF_CNT_MSB + 1;

   // All registered state in one packed struct
   typedef struct packed {
      logic valid;
      logic [REG_IDX_W-1:0] idx;
      logic [DW-1:0] data;
      logic cwr;
      logic carry;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   // Second operand: register or sign-extended nine-bit immediate
   logic [DW-1:0] opb;
   // Counts for the three shift forms
   logic signed [WC-1:0] word_cnt;
   logic signed [HC-1:0] half_cnt;
   // Shifter outputs
   logic [DW-1:0] word_res;
   logic word_c;
   logic word_lost;
   logic [HW-1:0] lo_res;
   logic [HW-1:0] hi_res;

   // Accumulate helper: shift destination left by one, add new bit
   function automatic logic [DW-1:0] accum(input logic [DW-1:0] d,
                                           input logic b);
      accum = {d[DW-2:0], b};
   endfunction

   always_comb
   begin
      opb = use_imm ? {{(DW-shift_unit_pkg::IMM9_W)
                        {nine_bit_immediate[shift_unit_pkg::IMM9_W-1]}},
                       nine_bit_immediate} : operand_b; // RL1
      // Short form sign-extends the four-bit count
      if (op == shift_unit_pkg::OP_ARITH_SHIFT_SHORT)
         word_cnt = WC'($signed(four_bit_immediate)); // RL6
      else
         word_cnt = $signed(opb[shift_unit_pkg::WORD_CNT_MSB:0]); // RL3 RL10
      half_cnt = $signed(opb[shift_unit_pkg::HALF_CNT_MSB:0]); // RL7
   end

   // Full-word shifter shared by plain, short and saturating forms
   arith_shifter #(.W(DW), .CW(WC)) u_word (
      .value(operand_a),
      .count(word_cnt),
      .result(word_res),
      .shifted_out_or(word_c),
      .sign_lost(word_lost)
   );

   // Each half has its own shifter, so no bit crosses halves
   arith_shifter #(.W(HW), .CW(HC)) u_lo (
      .value(operand_a[HW-1:0]),
      .count(half_cnt),
      .result(lo_res),
      .shifted_out_or(),
      .sign_lost()
   );
   arith_shifter #(.W(HW), .CW(HC)) u_hi (
      .value(operand_a[DW-1:HW]),
      .count(half_cnt),
      .result(hi_res),
      .shifted_out_or(),
      .sign_lost()
   );

   // Next-state: one result per start pulse with a known op, otherwise idle
   always_comb
   begin
      logic pa;
      logic pb;
      pa = operand_a[first_bit_position];
      pb = opb[second_bit_position];
      nxt_state = state_ff;
      nxt_state.valid = start; // RL12
      nxt_state.cwr = 1'b0;
      if (start)
      begin
         nxt_state.idx = dest_idx; // RL12
         case (shift_unit_pkg::shift_op_t'(op))
            shift_unit_pkg::OP_COMPARE_UNEQUAL_ACC:
               nxt_state.data = accum(destination_operand,
                                      operand_a != opb); // RL1
            shift_unit_pkg::OP_BIT_AND_ACC:
               nxt_state.data = accum(destination_operand, pa & pb); // RL2
            shift_unit_pkg::OP_BIT_AND_INV_ACC:
               nxt_state.data = accum(destination_operand, pa & ~pb); // RL2
            shift_unit_pkg::OP_BIT_NAND_ACC:
               nxt_state.data = accum(destination_operand, ~(pa & pb));
            shift_unit_pkg::OP_BIT_NOR_ACC:
               nxt_state.data = accum(destination_operand, ~(pa | pb));
            shift_unit_pkg::OP_BIT_OR_ACC:
               nxt_state.data = accum(destination_operand, pa | pb);
            shift_unit_pkg::OP_BIT_OR_INV_ACC:
               nxt_state.data = accum(destination_operand, pa | ~pb);
            shift_unit_pkg::OP_BIT_XNOR_ACC:
               nxt_state.data = accum(destination_operand, ~(pa ^ pb));
            shift_unit_pkg::OP_BIT_XOR_ACC:
               nxt_state.data = accum(destination_operand, pa ^ pb);
            shift_unit_pkg::OP_ARITH_SHIFT,
            shift_unit_pkg::OP_ARITH_SHIFT_SHORT:
            begin
               // Zero count spills nothing, so carry clears naturally
               nxt_state.data = word_res; // RL4
               nxt_state.cwr = 1'b1;
               nxt_state.carry = word_c; // RL5
               if (op == shift_unit_pkg::OP_ARITH_SHIFT_SHORT)
                  nxt_state.idx = src_idx; // RL6
            end
            shift_unit_pkg::OP_HALF_ARITH_SHIFT:
               nxt_state.data = {hi_res, lo_res}; // RL7 RL8
            shift_unit_pkg::OP_SAT_ARITH_SHIFT:
            begin
               // Only left shifts can lose sign bits
               if (word_lost)
                  nxt_state.data = operand_a[DW-1] ?
                     shift_unit_pkg::MAX_NEG :
                     shift_unit_pkg::MAX_POS; // RL9 RL11
               else
                  nxt_state.data = word_res; // RL10
            end
            default:
               nxt_state.valid = 1'b0; // Unknown op writes nothing
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign result_valid = state_ff.valid;
   assign result_idx = state_ff.idx;
   assign result = state_ff.data;
   assign carry_write = state_ff.cwr;
   assign carry_status_flag = state_ff.carry;

   // Helper copies of the selected bits for the checks
   logic pa_w;
   logic pb_w;
   assign pa_w = operand_a[first_bit_position];
   assign pb_w = opb[second_bit_position];

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence word_req_s;
      start && op == shift_unit_pkg::OP_ARITH_SHIFT && !word_cnt[WC-1];
   endsequence

   one_result_a: assert property ( // RL12
      start && op <= shift_unit_pkg::OP_SAT_ARITH_SHIFT |=> result_valid)
      else $error("start without result");
   unknown_op_a: assert property ( // RL12
      start && op > shift_unit_pkg::OP_SAT_ARITH_SHIFT |=> !result_valid)
      else $error("unknown op wrote a result");
   no_spurious_a: assert property (!start |=> !result_valid) // RL12
      else $error("result without start");
   unequal_acc_a: assert property ( // RL1
      start && op == shift_unit_pkg::OP_COMPARE_UNEQUAL_ACC |=>
      result == {$past(destination_operand[DW-2:0]),
                 $past(operand_a != opb)})
      else $error("unequal accumulate wrong");
   xor_acc_a: assert property ( // RL2
      start && op == shift_unit_pkg::OP_BIT_XOR_ACC |=>
      result[0] == ($past(pa_w) ^ $past(pb_w)))
      else $error("xor accumulate wrong");
   zero_carry_a: assert property ( // RL5
      start && op == shift_unit_pkg::OP_ARITH_SHIFT && word_cnt == 0 |=>
      carry_write && !carry_status_flag && result == $past(operand_a))
      else $error("zero shift carry not cleared");
   left_shift_a: assert property (word_req_s |=> // RL4
      result == $past(operand_a << word_cnt[WC-2:0]))
      else $error("left shift wrong");
   right32_a: assert property ( // RL4
      start && op == shift_unit_pkg::OP_ARITH_SHIFT && word_cnt == -32 |=>
      result == {DW{$past(operand_a[DW-1])}})
      else $error("shift right by 32 wrong");
   short_dest_a: assert property ( // RL6
      start && op == shift_unit_pkg::OP_ARITH_SHIFT_SHORT |=>
      result_idx == $past(src_idx))
      else $error("short form destination wrong");
   half_m16_a: assert property ( // RL8
      start && op == shift_unit_pkg::OP_HALF_ARITH_SHIFT && half_cnt == -16
      |=> result == {{HW{$past(operand_a[DW-1])}},
                     {HW{$past(operand_a[HW-1])}}})
      else $error("halfword -16 wrong");
   sat_value_a: assert property ( // RL11
      start && op == shift_unit_pkg::OP_SAT_ARITH_SHIFT && word_lost |=>
      result == ($past(operand_a[DW-1]) ? shift_unit_pkg::MAX_NEG :
                 shift_unit_pkg::MAX_POS))
      else $error("saturation value wrong");
endmodule // shift_compare_accumulate_unit

//--- sim/data_reg_file_model.sv
// Purpose: Data register file model that takes the unit's write-back
// Assumes: Sixteen 32-bit registers, written on result_valid
// Notes: Cleared by reset, so a lost write shows as a stale zero
`timescale 1ns/1ns
module data_reg_file_model
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Write-back from the unit
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [31:0] wr_data,
   // Register contents seen by the bench
   output logic [15:0][31:0] regs
);
   // Only the register named by the unit changes
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         regs <= '0;
      end
      else if (wr_en)
      begin
         regs[wr_idx] <= wr_data;
      end
   end
endmodule // data_reg_file_model

//--- sim/testbench.sv
// Purpose: Self-checking bench for the shift and accumulate unit
// Assumes: One request every three cycles in the table loop
// Notes: Accumulate rows use p1=4, p2=7 and a fixed destination
`timescale 1ns/1ns
module testbench;
   // One table row: request beside expected answer
   typedef struct packed {
      logic [3:0] op;
      logic imm;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] exp;
      logic cw;
      logic c;
   } row_t;
   localparam int NROWS = 33;
   logic ref_clk, rst, start, use_imm, result_valid, carry_write, cflag;
   logic [3:0] op, didx, sidx, ridx, eidx;
   logic [8:0] imm9;
   logic [3:0] imm4;
   logic [4:0] p1, p2;
   logic [31:0] a, b, d, result;
   logic [15:0][31:0] regs;
   int bad_count = 0;
   int check_count = 0;
   row_t r;
   row_t rows [NROWS] = '{
      '{4'h0,1'h0,32'h5,32'h5,32'h2,1'h0,1'h0},
      '{4'h0,1'h0,32'h5,32'h6,32'h3,1'h0,1'h0},
      '{4'h0,1'h1,32'hFFFFFFFF,32'h1FF,32'h2,1'h0,1'h0},
      '{4'h1,1'h0,32'h10,32'h0,32'h2,1'h0,1'h0},
      '{4'h2,1'h0,32'h10,32'h0,32'h3,1'h0,1'h0},
      '{4'h3,1'h0,32'h10,32'h0,32'h3,1'h0,1'h0},
      '{4'h4,1'h0,32'h10,32'h0,32'h2,1'h0,1'h0},
      '{4'h5,1'h0,32'h10,32'h0,32'h3,1'h0,1'h0},
      '{4'h6,1'h0,32'h10,32'h0,32'h3,1'h0,1'h0},
      '{4'h7,1'h0,32'h10,32'h0,32'h2,1'h0,1'h0},
      '{4'h8,1'h0,32'h10,32'h0,32'h3,1'h0,1'h0},
      '{4'h1,1'h0,32'h10,32'h80,32'h3,1'h0,1'h0},
      '{4'h9,1'h0,32'h1,32'h2,32'h4,1'h1,1'h0},
      '{4'h9,1'h0,32'h80000001,32'h3F,32'hC0000000,1'h1,1'h1},
      '{4'h9,1'h0,32'h80000000,32'h3F,32'hC0000000,1'h1,1'h0},
      '{4'h9,1'h0,32'h80000000,32'h20,32'hFFFFFFFF,1'h1,1'h1},
      '{4'h9,1'h1,32'h7FFFFFFF,32'h20,32'h0,1'h1,1'h1},
      '{4'h9,1'h0,32'hF0000000,32'h0,32'hF0000000,1'h1,1'h0},
      '{4'h9,1'h0,32'hF0000000,32'h1F,32'h0,1'h1,1'h1},
      '{4'h9,1'h0,32'h40000000,32'hFFFFFF01,32'h80000000,1'h1,1'h0},
      '{4'hA,1'h0,32'h100,32'h8,32'h1,1'h1,1'h0},
      '{4'hA,1'h0,32'hFFFFFFFF,32'h7,32'hFFFFFF80,1'h1,1'h1},
      '{4'hA,1'h0,32'hFF,32'hF7,32'h7F80,1'h1,1'h0},
      '{4'hB,1'h0,32'h80001234,32'h10,32'hFFFF0000,1'h0,1'h0},
      '{4'hB,1'h0,32'h80004001,32'h1,32'h8002,1'h0,1'h0},
      '{4'hB,1'h0,32'h12348000,32'h1C,32'h0123F800,1'h0,1'h0},
      '{4'hB,1'h1,32'h80000001,32'hF,32'h8000,1'h0,1'h0},
      '{4'hC,1'h0,32'h40000000,32'h1,32'h7FFFFFFF,1'h0,1'h0},
      '{4'hC,1'h0,32'hC0000000,32'h1,32'h80000000,1'h0,1'h0},
      '{4'hC,1'h0,32'h90000000,32'h1,32'h80000000,1'h0,1'h0},
      '{4'hC,1'h0,32'h80000000,32'h20,32'hFFFFFFFF,1'h0,1'h0},
      '{4'hC,1'h0,32'h3,32'h1D,32'h60000000,1'h0,1'h0},
      '{4'hC,1'h1,32'h3,32'h1E,32'h7FFFFFFF,1'h0,1'h0}
   };
   shift_compare_accumulate_unit #(.REG_IDX_W(4)) dut_u (.ref_clk(ref_clk),
      .rst(rst), .start(start), .op(op), .use_imm(use_imm),
      .nine_bit_immediate(imm9), .four_bit_immediate(imm4),
      .first_bit_position(p1), .second_bit_position(p2), .dest_idx(didx),
      .src_idx(sidx), .operand_a(a), .operand_b(b), .destination_operand(d),
      .result_valid(result_valid), .result_idx(ridx), .result(result),
      .carry_write(carry_write), .carry_status_flag(cflag));
   data_reg_file_model rf_u (.ref_clk(ref_clk), .rst(rst),
      .wr_en(result_valid), .wr_idx(ridx), .wr_data(result), .regs(regs));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      check_count++;
      if (got !== exp)
      begin
         $display("BAD %0t %s", $time, msg);
         bad_count++;
      end
   endtask
   // Single closing point of the run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Free-running 125 MHz clock
   initial
   begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Hang guard, well past the expected run length
   initial
   begin
      #20000;
      bad_count++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      {rst, start, op, use_imm, imm9, imm4, didx, sidx, a, b} = '0;
      rst = 1'h1;
      p1 = 5'h4;
      p2 = 5'h7;
      d = 32'h80000001;
      repeat (16) @(posedge ref_clk);
      #1 rst = 1'h0;
      chk(result, 32'h0, "reset result");
      chk({29'h0, result_valid, carry_write, cflag}, 32'h0, "reset flags");
      $display("reset release test done");
      for (int i = 0; i < NROWS; i++)
      begin
         r = rows[i];
         @(posedge ref_clk);
         #1;
         op = r.op;
         use_imm = r.imm;
         a = r.a;
         b = r.imm ? ~r.b : r.b;
         imm9 = r.b[8:0];
         imm4 = r.b[3:0];
         didx = i[3:0];
         sidx = ~didx;
         eidx = (r.op == 4'hA) ? sidx : didx;
         start = 1'h1;
         @(posedge ref_clk);
         #1 start = 1'h0;
         chk({31'h0, result_valid}, 32'h1, "no valid");
         chk(result, r.exp, "result");
         chk({28'h0, ridx}, {28'h0, eidx}, "index");
         chk({31'h0, carry_write}, {31'h0, r.cw}, "carry write");
         if (r.cw)
            chk({31'h0, cflag}, {31'h0, r.c}, "carry");
         @(posedge ref_clk);
         #1 chk({31'h0, result_valid}, 32'h0, "long valid");
         chk(regs[eidx], r.exp, "write-back");
      end
      $display("table test done");
      // Back-to-back requests on consecutive edges
      @(posedge ref_clk);
      #1 {op, use_imm, a, b, start} = {4'h9, 1'h0, 32'h1, 32'h1, 1'h1};
      @(posedge ref_clk);
      #1 {a, b} = {32'h3, 32'h3F};
      chk(result, 32'h2, "first of pair");
      @(posedge ref_clk);
      #1 start = 1'h0;
      chk({30'h0, result_valid, cflag}, 32'h3, "second flags");
      chk(result, 32'h1, "second");
      $display("back to back test done");
      // Unknown operation code gives no write
      @(posedge ref_clk);
      #1 {op, start} = {4'hD, 1'h1};
      @(posedge ref_clk);
      #1 start = 1'h0;
      chk({30'h0, result_valid, carry_write}, 32'h0, "unknown op");
      $display("unknown op test done");
      // Reset in mid-run clears the outputs
      rst = 1'h1;
      #1 chk(result, 32'h0, "re-reset result");
      chk({29'h0, result_valid, carry_write, cflag}, 32'h0, "re-reset flags");
      $display("reset test done");
      give_verdict();
   end
endmodule // testbench
